// *** include/ppsc_pkg.sv ***
// package: register map, field masks and carriers for the port pull and slew control block
`default_nettype none

package ppsc_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0]  ADDR_PULL_ENABLE   = 8'h00;
	localparam logic [7:0]  ADDR_PULL_POLARITY = 8'h04;
	localparam logic [7:0]  ADDR_SLEW_ENABLE   = 8'h08;

	// ==========================================================
	// implemented bits and reset values
	localparam logic [7:0]  MASK_PULL_ENABLE   = 8'h3F;
	localparam logic [7:0]  MASK_PULL_POLARITY = 8'h37;
	localparam logic [7:0]  MASK_SLEW_ENABLE   = 8'h3B;
	localparam logic [7:0]  RESET_REG          = 8'h00;
	localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
	localparam logic [31:0] ZERO_WORD          = 32'h0000_0000;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [7:0] pull_device_enable;
		logic [7:0] pull_polarity_select;
		logic [7:0] output_slew_limit_enable;
	} ppsc_regs_t;

	typedef struct packed {
		logic [7:0] pull_up_on;
		logic [7:0] pull_down_on;
		logic [7:0] slew_limit_on;
	} ppsc_pads_t;

endpackage

`default_nettype wire

// *** logic/ppsc_top.sv ***
// module: pin pull and slew control registers with AHB-Lite slave
`default_nettype none

module ppsc_top #(
	parameter int PINS = 6
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RESETN,
	input  wire logic              HSEL,
	input  wire logic [7:0]        HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic      [31:0]       HRDATA,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	input  wire logic [PINS-1:0]   PIN_DIRECTION,
	input  wire logic [PINS-1:0]   PERIPH_OUT_EN,
	input  wire logic [PINS-1:0]   ANALOG_OWNS,
	output logic      [PINS-1:0]   PULL_UP_EN,
	output logic      [PINS-1:0]   PULL_DOWN_EN,
	output logic      [PINS-1:0]   SLEW_LIMIT_EN
);

	// ==========================================================
	// bus slave; always zero wait states
	ppsc_pkg::ppsc_regs_t regs;
	ppsc_pkg::ppsc_regs_t next_regs;
	ppsc_pkg::ppsc_pads_t pads;
	ppsc_pkg::ppsc_pads_t next_pads;
	logic                 wr_pend;
	logic                 next_wr_pend;
	logic [7:0]           wr_addr;
	logic [7:0]           next_wr_addr;
	logic [31:0]          next_rdata;
	logic                 take;

	assign take      = HSEL && HREADY && HTRANS == ppsc_pkg::HTRANS_NONSEQ;
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	always_comb begin
		next_regs    = regs;
		next_wr_pend = take && HWRITE;
		next_wr_addr = take ? HADDR : wr_addr;
		next_rdata   = ppsc_pkg::ZERO_WORD;
		// writes touch only these three registers, never data or direction
		if (wr_pend) begin
			case (wr_addr)
				ppsc_pkg::ADDR_PULL_ENABLE: begin
					next_regs.pull_device_enable = HWDATA[7:0] & ppsc_pkg::MASK_PULL_ENABLE;
				end
				ppsc_pkg::ADDR_PULL_POLARITY: begin
					next_regs.pull_polarity_select = HWDATA[7:0] & ppsc_pkg::MASK_PULL_POLARITY;
				end
				ppsc_pkg::ADDR_SLEW_ENABLE: begin
					next_regs.output_slew_limit_enable = HWDATA[7:0] & ppsc_pkg::MASK_SLEW_ENABLE;
				end
				default: begin
					next_regs = regs;
				end
			endcase
		end
		// read data launched at the address phase, valid in the data phase
		if (take && !HWRITE) begin
			case (HADDR)
				ppsc_pkg::ADDR_PULL_ENABLE:   next_rdata[7:0] = regs.pull_device_enable;
				ppsc_pkg::ADDR_PULL_POLARITY: next_rdata[7:0] = regs.pull_polarity_select;
				ppsc_pkg::ADDR_SLEW_ENABLE:   next_rdata[7:0] = regs.output_slew_limit_enable;
				default:                      next_rdata = ppsc_pkg::ZERO_WORD;
			endcase
		end
	end

	// no low-power input: state is simply kept while the clock is gated
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			regs    <= '{default: ppsc_pkg::RESET_REG};
			wr_pend <= 1'b0;
			wr_addr <= ppsc_pkg::RESET_REG;
			HRDATA  <= ppsc_pkg::ZERO_WORD;
		end else begin
			regs    <= next_regs;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			HRDATA  <= next_rdata;
		end
	end

	// ==========================================================
	// pad controls, one slice per pin
	// per-pin terms are nets, so that one process alone writes each register group
	wire logic [PINS-1:0] pin_drives;
	wire logic [PINS-1:0] pin_pull_on;
	wire logic [PINS-1:0] pin_up;
	wire logic [PINS-1:0] pin_down;
	wire logic [PINS-1:0] pin_slew;

	for (genvar i = 0; i < PINS; i++) begin : g_pin
		// a peripheral output counts as driving even with the direction bit clear
		assign pin_drives[i]  = PIN_DIRECTION[i] | PERIPH_OUT_EN[i];
		assign pin_pull_on[i] = regs.pull_device_enable[i] & ~pin_drives[i]
			& ~ANALOG_OWNS[i];
		// polarity alone never turns a device on
		assign pin_up[i]      = pin_pull_on[i] & ~regs.pull_polarity_select[i];
		assign pin_down[i]    = pin_pull_on[i] & regs.pull_polarity_select[i];
		// slew limit only reaches a driven pin; inputs see no effect
		assign pin_slew[i]    = regs.output_slew_limit_enable[i] & pin_drives[i];
	end

	// bits above the pin count stay at reset so the carrier never holds stray ones
	always_comb begin
		next_pads                         = '{default: ppsc_pkg::RESET_REG};
		next_pads.pull_up_on[PINS-1:0]    = pin_up;
		next_pads.pull_down_on[PINS-1:0]  = pin_down;
		next_pads.slew_limit_on[PINS-1:0] = pin_slew;
	end

	// one cycle of latency buys glitch-free pad controls
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			pads <= '{default: ppsc_pkg::RESET_REG};
		end else begin
			pads <= next_pads;
		end
	end

	assign PULL_UP_EN    = pads.pull_up_on[PINS-1:0];
	assign PULL_DOWN_EN  = pads.pull_down_on[PINS-1:0];
	assign SLEW_LIMIT_EN = pads.slew_limit_on[PINS-1:0];

	// ==========================================================
	// pad checks on fixed pins
	a_pull_off_output: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		(PIN_DIRECTION[0] || PERIPH_OUT_EN[0]) |=> !PULL_UP_EN[0] && !PULL_DOWN_EN[0])
		else $error("pull on while pin drives");

	a_pull_off_analog: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		ANALOG_OWNS[1] |=> !PULL_UP_EN[1] && !PULL_DOWN_EN[1])
		else $error("pull on under analog");

	a_pull_needs_enable: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		!regs.pull_device_enable[0] |=> !PULL_UP_EN[0] && !PULL_DOWN_EN[0])
		else $error("pull on without enable");

	a_pull_turns_on: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		regs.pull_device_enable[2] && !PIN_DIRECTION[2] && !PERIPH_OUT_EN[2]
		&& !ANALOG_OWNS[2] |=> PULL_UP_EN[2] != PULL_DOWN_EN[2])
		else $error("enabled pull not on");

	a_polarity_select: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		regs.pull_polarity_select[1] |=> !PULL_UP_EN[1])
		else $error("pullup with pulldown selected");

	a_slew_input: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		!PIN_DIRECTION[0] && !PERIPH_OUT_EN[0] |=> !SLEW_LIMIT_EN[0])
		else $error("slew on input pin");

	// ==========================================================
	// register checks
	a_slew_reserved: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		regs.output_slew_limit_enable[2] == 1'b0)
		else $error("reserved slew bit set");

	a_enable_reserved: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		(regs.pull_device_enable & ~ppsc_pkg::MASK_PULL_ENABLE) == ppsc_pkg::RESET_REG)
		else $error("reserved pull enable bit set");

	a_polarity_reserved: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		(regs.pull_polarity_select & ~ppsc_pkg::MASK_PULL_POLARITY) == ppsc_pkg::RESET_REG)
		else $error("reserved polarity bit set");

	// reset checks run through reset itself, so they carry no disable
	a_reset_clear: assert property (
		@(posedge SYS_CLK)
		!RESETN |=> regs.pull_device_enable == ppsc_pkg::RESET_REG)
		else $error("pull enable not cleared");

	a_reset_others: assert property (
		@(posedge SYS_CLK)
		!RESETN |=> regs.pull_polarity_select == ppsc_pkg::RESET_REG
		&& regs.output_slew_limit_enable == ppsc_pkg::RESET_REG)
		else $error("polarity or slew not cleared");

	a_reset_outputs: assert property (
		@(posedge SYS_CLK)
		!RESETN |=> {PULL_UP_EN, PULL_DOWN_EN, SLEW_LIMIT_EN} == '0
		&& HRDATA == ppsc_pkg::ZERO_WORD)
		else $error("outputs not cleared by reset");

	// a write is armed at the address phase and lands at the end of the data phase
	a_write_arms: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		take && HWRITE |=> wr_pend && wr_addr == $past(HADDR))
		else $error("write not armed");

	a_write_enable: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		wr_pend && wr_addr == ppsc_pkg::ADDR_PULL_ENABLE
		|=> regs.pull_device_enable == ($past(HWDATA[7:0]) & ppsc_pkg::MASK_PULL_ENABLE))
		else $error("pull enable write lost");

	a_write_polarity: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		wr_pend && wr_addr == ppsc_pkg::ADDR_PULL_POLARITY
		|=> regs.pull_polarity_select == ($past(HWDATA[7:0]) & ppsc_pkg::MASK_PULL_POLARITY))
		else $error("polarity write lost");

	a_write_stores: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		wr_pend && wr_addr == ppsc_pkg::ADDR_SLEW_ENABLE
		|=> regs.output_slew_limit_enable == ($past(HWDATA[7:0]) & ppsc_pkg::MASK_SLEW_ENABLE))
		else $error("slew write lost");

	a_write_unmapped: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		wr_pend && wr_addr != ppsc_pkg::ADDR_PULL_ENABLE
		&& wr_addr != ppsc_pkg::ADDR_PULL_POLARITY
		&& wr_addr != ppsc_pkg::ADDR_SLEW_ENABLE |=> $stable(regs))
		else $error("unmapped write changed a register");

	a_hold_idle: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		!wr_pend |=> $stable(regs))
		else $error("settings changed without write");

	// ==========================================================
	// read path checks
	a_read_upper_zero: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		HRDATA[31:8] == '0)
		else $error("upper read bits not zero");

	// the data bus is zeroed when no read is in flight, so stale values never linger
	a_read_idle_zero: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		!(take && !HWRITE) |=> HRDATA == ppsc_pkg::ZERO_WORD)
		else $error("read data without a read");

	a_read_enable: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		take && !HWRITE && HADDR == ppsc_pkg::ADDR_PULL_ENABLE
		|=> HRDATA[7:0] == $past(regs.pull_device_enable))
		else $error("pull enable read wrong");

	a_read_polarity: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		take && !HWRITE && HADDR == ppsc_pkg::ADDR_PULL_POLARITY
		|=> HRDATA[7:0] == $past(regs.pull_polarity_select))
		else $error("polarity read wrong");

	a_read_slew: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		take && !HWRITE && HADDR == ppsc_pkg::ADDR_SLEW_ENABLE
		|=> HRDATA[7:0] == $past(regs.output_slew_limit_enable))
		else $error("slew read wrong");

	a_read_unmapped: assert property (
		@(posedge SYS_CLK) disable iff (!RESETN)
		take && !HWRITE && HADDR != ppsc_pkg::ADDR_PULL_ENABLE
		&& HADDR != ppsc_pkg::ADDR_PULL_POLARITY
		&& HADDR != ppsc_pkg::ADDR_SLEW_ENABLE |=> HRDATA == ppsc_pkg::ZERO_WORD)
		else $error("unmapped read not zero");

	// ==========================================================
	// per-pin checks; every pin is watched on every path
	for (genvar k = 0; k < PINS; k++) begin : g_chk
		a_pin_drive_off: assert property (
			@(posedge SYS_CLK) disable iff (!RESETN)
			PIN_DIRECTION[k] || PERIPH_OUT_EN[k] |=> !PULL_UP_EN[k] && !PULL_DOWN_EN[k])
			else $error("pull on while pin drives");

		a_pin_analog_off: assert property (
			@(posedge SYS_CLK) disable iff (!RESETN)
			ANALOG_OWNS[k] |=> !PULL_UP_EN[k] && !PULL_DOWN_EN[k])
			else $error("pull on under analog");

		a_pin_no_enable: assert property (
			@(posedge SYS_CLK) disable iff (!RESETN)
			!regs.pull_device_enable[k] |=> !PULL_UP_EN[k] && !PULL_DOWN_EN[k])
			else $error("pull on without enable");

		a_pin_up_on: assert property (
			@(posedge SYS_CLK) disable iff (!RESETN)
			regs.pull_device_enable[k] && !regs.pull_polarity_select[k]
			&& !PIN_DIRECTION[k] && !PERIPH_OUT_EN[k] && !ANALOG_OWNS[k] |=> PULL_UP_EN[k])
			else $error("selected pullup not on");

		a_pin_down_on: assert property (
			@(posedge SYS_CLK) disable iff (!RESETN)
			regs.pull_device_enable[k] && regs.pull_polarity_select[k]
			&& !PIN_DIRECTION[k] && !PERIPH_OUT_EN[k] && !ANALOG_OWNS[k] |=> PULL_DOWN_EN[k])
			else $error("selected pulldown not on");

		a_pin_not_both: assert property (
			@(posedge SYS_CLK) disable iff (!RESETN)
			!(PULL_UP_EN[k] && PULL_DOWN_EN[k]))
			else $error("pullup and pulldown on together");

		a_pin_slew_out: assert property (
			@(posedge SYS_CLK) disable iff (!RESETN)
			regs.output_slew_limit_enable[k] && (PIN_DIRECTION[k] || PERIPH_OUT_EN[k])
			|=> SLEW_LIMIT_EN[k])
			else $error("slew limit not applied");

		a_pin_slew_in: assert property (
			@(posedge SYS_CLK) disable iff (!RESETN)
			!PIN_DIRECTION[k] && !PERIPH_OUT_EN[k] |=> !SLEW_LIMIT_EN[k])
			else $error("slew on input pin");
	end

endmodule

`default_nettype wire

// *** tb/ppsc_board.sv ***
// board model: level seen on each pin through the pull devices
`default_nettype none
module ppsc_board #(
	parameter int PINS = 6
) (
	input  wire logic            sys_clk,
	input  wire logic [PINS-1:0] pull_up_en,
	input  wire logic [PINS-1:0] pull_down_en,
	output logic      [PINS-1:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// floating pins
	// an unpulled pin wanders every cycle so a stale value cannot pass
	logic [PINS-1:0] wander = '0;
	always @(posedge sys_clk) wander <= ~wander;
	assign pin_level = pull_up_en | (~pull_down_en & wander);
endmodule
`default_nettype wire

// *** tb/port_pin_pull_slew_control_bench.sv ***
// bench: bus tasks and pull and slew scenarios
`default_nettype none
module port_pin_pull_slew_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// stimulus and wiring
	logic        clk = 0, rst_n = 0, hsel = 0, hwr = 0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [5:0]  dir = 6'h00, per = 6'h00, ana = 6'h00;
	wire  [31:0] hrdata;
	wire         hrdy, hresp;
	wire  [5:0]  up, dn, sl, lvl;
	logic [7:0]  a[4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
	logic [7:0]  m[4] = '{8'h3F, 8'h37, 8'h3B, 8'h00};
	int          bad_count = 0, samples_checked = 0, cycles = 0;
	always #2.5 clk = ~clk;
	ppsc_top dut_u (.SYS_CLK(clk), .RESETN(rst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwr), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
		.HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .PIN_DIRECTION(dir),
		.PERIPH_OUT_EN(per), .ANALOG_OWNS(ana), .PULL_UP_EN(up), .PULL_DOWN_EN(dn),
		.SLEW_LIMIT_EN(sl));
	ppsc_board board_u (.sys_clk(clk), .pull_up_en(up), .pull_down_en(dn), .pin_level(lvl));
	// ==========================================================
	// tasks
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(logic wr, logic [7:0] ad, logic [31:0] d, logic [31:0] exp);
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= ppsc_pkg::HTRANS_NONSEQ;
		hwr <= wr;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		if (!wr) check("read data", exp, hrdata);
		check("response", 32'h0000_0000, {31'h0, hresp});
	endtask
	// pads are registered: three edges leave them settled
	task automatic pads(logic [5:0] pe, logic [5:0] pol, logic [5:0] se);
		logic [5:0] off;
		repeat (3) @(posedge clk);
		// pin controls read only now, once a change made just before the call has landed
		off = dir | per | ana;
		check("pull up", pe & ~pol & ~off, up);
		check("pull down", pe & pol & ~off, dn);
		check("slew", se & (dir | per), sl);
		check("pin level", pe & ~pol & ~off, lvl & (up | dn));
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		pads(6'h00, 6'h00, 6'h00);
		for (int i = 0; i < 4; i++) bus(0, a[i], 0, 0);
		for (int i = 0; i < 4; i++) bus(1, a[i], 32'hFFFF_FFFF, 0);
		for (int i = 0; i < 4; i++) bus(0, a[i], 0, {24'h0, m[i]});
		$display("test registers done");
		bus(1, a[0], 32'h0000_000C, 0);
		bus(1, a[1], 32'h0000_0037, 0);
		bus(1, a[2], 32'h0000_003B, 0);
		pads(6'h0C, 6'h37, 6'h3B);
		bus(1, a[0], 32'h0000_003F, 0);
		pads(6'h3F, 6'h37, 6'h3B);
		dir <= 6'h3F;
		pads(6'h3F, 6'h37, 6'h3B);
		dir <= 6'h00;
		per <= 6'h09;
		pads(6'h3F, 6'h37, 6'h3B);
		per <= 6'h00;
		ana <= 6'h12;
		pads(6'h3F, 6'h37, 6'h3B);
		ana <= 6'h00;
		bus(1, a[2], 32'h0000_0000, 0);
		pads(6'h3F, 6'h37, 6'h00);
		$display("test pads done");
		// a second reset in mid-run must clear every setting again
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) bus(0, a[i], 0, 0);
		pads(6'h00, 6'h00, 6'h00);
		$display("test reset done");
		close_out();
	end
endmodule
`default_nettype wire
